// >>> core/btf_framer.sv
/*
  Button telegram framer: turns energy bar push/release into a signed,
  check-summed data telegram streamed out byte by byte.
  Assumes synchronous contact inputs, an external AES-128 engine with a
  req/ack handshake, and a byte sink with valid/ready.
*/
// The implementer's own choices: the APB slave port and the register offsets.
// Function
// [RULE1] frame ends with two-byte CRC16 check sum
// [RULE2] payload: control, identifier, counter, command, signature
// [RULE3] control word is 0x308C
// [RULE4] fixed per-unit four-byte identifier in telegram; the framer lets software rewrite it over APB while idle
// [RULE5] counter only increases, never reused
// [RULE6] single-contact command codes, push even
// [RULE7] two-contact command codes, push even
// [RULE8] push uses held contacts, release prior ones
// [RULE9] four-byte signature over payload with AES-128
// [RULE10] signature uses CCM mode
// [RULE11] nonce: id, id, counter, status 0x05
// [RULE12] nonce fields least significant byte first
// [RULE13] authenticate eleven bytes starting 0x8C 0x30
// [RULE14] per-unit 128-bit key feeds the cipher
// [RULE15] signature appended at payload end
// [RULE16] receiver recomputes the signature
// [RULE17] receiver accepts only matching signatures
// [RULE18] receiver rejects equal or lower counters
// [RULE19] zero preamble then 0xA7 before length
// [RULE20] length byte is 24
// [RULE21] frame control field is 0x0801
// [RULE22] multibyte fields go out low byte first; the framer sends the signature high byte first
// [RULE23] CRC zero start, bit-reflected processing
// [RULE24] counter advances before each signature
`timescale 1ns/1ps
`default_nettype none

module btf_framer #(
  parameter logic [31:0] UNIT_ID_INIT = 32'h1234_5678 // arbitrary value
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // actuator and contacts
  input  wire logic                  energy_bar,
  input  wire logic                  contact_a_first,
  input  wire logic                  contact_a_second,
  input  wire logic                  contact_b_first,
  input  wire logic                  contact_b_second,
  // cipher engine
  output logic                       aes_req,
  output btf_pkg::btf_aes_req_s      aes_out,
  input  wire logic                  aes_ack,
  input  wire logic [127:0]          aes_result,
  // byte stream to the radio
  output logic      [7:0]            tx_data,
  output logic                       tx_valid,
  output logic                       tx_last,
  input  wire logic                  tx_ready
);

  if (UNIT_ID_INIT == 32'h0000_0000) begin : g_bad_id
    $error("unit identifier must not be zero");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] swap32(input logic [31:0] v);
    swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  // contacts ordered {a_first, a_second, b_first, b_second}
  function automatic logic [7:0] encode_cmd(input logic [3:0] c, input logic rel);
    logic [7:0] base;
    case (c)
      4'b0001: base = btf_pkg::CMD_BS;   // RULE6
      4'b0010: base = btf_pkg::CMD_BF;
      4'b0100: base = btf_pkg::CMD_AS;
      4'b1000: base = btf_pkg::CMD_AF;
      4'b0011: base = btf_pkg::CMD_BFBS; // RULE7
      4'b0101: base = btf_pkg::CMD_ASBS;
      4'b0110: base = btf_pkg::CMD_ASBF;
      4'b1001: base = btf_pkg::CMD_AFBS;
      4'b1010: base = btf_pkg::CMD_AFBF;
      4'b1100: base = btf_pkg::CMD_AFAS;
      default: base = btf_pkg::CMD_NONE;
    endcase
    encode_cmd = {base[7:1], rel};
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ btf_pkg::CRC_POLY_REFL) : (c >> 1); // RULE23
    end
    crc_step = c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  btf_pkg::btf_state_e state;
  logic [31:0]         ident;
  logic [127:0]        key;
  logic [31:0]         counter;
  logic                enable;
  logic [7:0]          mac_seq;
  logic [7:0]          cmd;
  logic [1:0]          op;
  logic [127:0]        x1;
  logic [31:0]         tag;
  logic [31:0]         sig;
  logic [15:0]         crc;
  logic [4:0]          send_idx;
  logic [4:0]          byte_idx;
  logic                bar_q;
  logic [3:0]          held;

  ////////////////////////////////////////////////////////////////////////
  // actuator events

  wire [3:0] contacts  = {contact_a_first, contact_a_second, contact_b_first, contact_b_second};
  wire       push_ev   = energy_bar & ~bar_q;
  wire       rel_ev    = ~energy_bar & bar_q;
  wire       idle      = (state == btf_pkg::ST_IDLE);
  wire       exhausted = (counter == 32'hFFFF_FFFF);
  wire       start     = idle & enable & ~exhausted & (push_ev | rel_ev);
  // release reports what was held in the last cycle the bar was down
  wire [3:0] snap      = push_ev ? contacts : held; // RULE8

  // held contacts follow the inputs only while the bar is pressed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bar_q <= 1'b0;
      held  <= 4'h0;
    end
    else
    begin
      bar_q <= energy_bar;
      if (energy_bar)
        held <= contacts;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cipher blocks for the three encryptions

  wire [103:0] nonce = {swap32(ident), swap32(ident), swap32(counter),
                        btf_pkg::NONCE_STATUS}; // RULE11 RULE12
  wire [127:0] blk_b0 = {btf_pkg::CCM_B0_FLAGS, nonce, 16'h0000}; // RULE10
  wire [127:0] blk_b1 = {btf_pkg::AUTH_LEN, btf_pkg::TELEGRAM_CTRL[7:0],
                         btf_pkg::TELEGRAM_CTRL[15:8], swap32(ident),
                         swap32(counter), cmd, 24'h00_0000}; // RULE13
  wire [127:0] blk_a0 = {btf_pkg::CCM_A0_FLAGS, nonce, 16'h0000};
  wire [127:0] blk_sel = (op == 2'd0) ? blk_b0 :
                         (op == 2'd1) ? (x1 ^ blk_b1) : blk_a0; // RULE9

  ////////////////////////////////////////////////////////////////////////
  // frame byte selection, low byte first for multibyte fields except the signature, which goes out high byte first

  logic [7:0] frame_byte;
  always_comb
  begin
    case (send_idx)
      5'd0, 5'd1, 5'd2, 5'd3: frame_byte = btf_pkg::PREAMBLE_BYTE; // RULE19
      5'd4:  frame_byte = btf_pkg::START_BYTE;
      5'd5:  frame_byte = btf_pkg::LENGTH_BYTE;                   // RULE20
      5'd6:  frame_byte = btf_pkg::FRAME_CTRL[7:0];               // RULE21 RULE22
      5'd7:  frame_byte = btf_pkg::FRAME_CTRL[15:8];
      5'd8:  frame_byte = mac_seq;
      5'd9, 5'd10, 5'd11, 5'd12: frame_byte = btf_pkg::BCAST_BYTE;
      5'd13: frame_byte = btf_pkg::TELEGRAM_CTRL[7:0];            // RULE2 RULE3
      5'd14: frame_byte = btf_pkg::TELEGRAM_CTRL[15:8];
      5'd15: frame_byte = ident[7:0];                             // RULE4
      5'd16: frame_byte = ident[15:8];
      5'd17: frame_byte = ident[23:16];
      5'd18: frame_byte = ident[31:24];
      5'd19: frame_byte = counter[7:0];                           // RULE5
      5'd20: frame_byte = counter[15:8];
      5'd21: frame_byte = counter[23:16];
      5'd22: frame_byte = counter[31:24];
      5'd23: frame_byte = cmd;
      5'd24: frame_byte = sig[31:24];                             // RULE15
      5'd25: frame_byte = sig[23:16];
      5'd26: frame_byte = sig[15:8];
      5'd27: frame_byte = sig[7:0];
      5'd28: frame_byte = crc[7:0];                               // RULE1
      5'd29: frame_byte = crc[15:8];
      default: frame_byte = 8'h00;
    endcase
  end

  wire tx_load   = (state == btf_pkg::ST_SEND) & (~tx_valid | tx_ready);
  wire tx_done   = tx_load & (send_idx == btf_pkg::FRAME_BYTES);
  wire crc_cover = (send_idx >= btf_pkg::IDX_LENGTH) & (send_idx < btf_pkg::IDX_CRC_LO);

  ////////////////////////////////////////////////////////////////////////
  // telegram sequencer

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state   <= btf_pkg::ST_IDLE;
      cmd     <= btf_pkg::CMD_NONE;
      op      <= 2'd0;
      x1      <= 128'h0;
      tag     <= 32'h0000_0000;
      sig     <= 32'h0000_0000;
      mac_seq <= btf_pkg::MAC_SEQ_RESET;
      aes_req <= 1'b0;
      aes_out <= '0;
    end
    else
    begin
      case (state)
        btf_pkg::ST_IDLE:
          if (start)
          begin
            cmd     <= encode_cmd(snap, rel_ev);
            op      <= 2'd0;
            mac_seq <= mac_seq + 8'h01;
            state   <= btf_pkg::ST_ISSUE;
          end
        btf_pkg::ST_ISSUE:
        begin
          aes_req       <= 1'b1;
          aes_out.block <= blk_sel;
          aes_out.key   <= key; // RULE14
          state         <= btf_pkg::ST_WAIT;
        end
        btf_pkg::ST_WAIT:
          if (aes_ack)
          begin
            aes_req <= 1'b0;
            op      <= op + 2'd1;
            if (op == 2'd0)
              x1 <= aes_result;
            if (op == 2'd1)
              tag <= aes_result[127:96];
            // tag masked with the first key-stream word
            if (op == 2'd2)
              sig <= tag ^ aes_result[127:96]; // RULE9
            state <= (op == 2'd2) ? btf_pkg::ST_SEND : btf_pkg::ST_ISSUE;
          end
        btf_pkg::ST_SEND:
          if (tx_done)
            state <= btf_pkg::ST_IDLE;
        default: state <= btf_pkg::ST_IDLE;
      endcase
    end
  end

  // byte stream; the check sum covers the length byte onward
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      send_idx <= 5'd0;
      byte_idx <= 5'd0;
      crc      <= btf_pkg::CRC_INIT;
    end
    else if (idle)
    begin
      send_idx <= 5'd0;
      crc      <= btf_pkg::CRC_INIT;
    end
    else if (tx_load)
    begin
      tx_valid <= ~tx_done;
      tx_last  <= (send_idx == btf_pkg::IDX_LAST);
      if (!tx_done)
      begin
        tx_data  <= frame_byte;
        byte_idx <= send_idx;
        send_idx <= send_idx + 5'd1;
      end
      if (crc_cover)
        crc <= crc_step(crc, frame_byte); // RULE1 RULE23
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb register file; answer one cycle after setup

  wire        setup   = psel & ~penable & ~pready;
  wire        access  = psel & penable & pready;
  wire        mapped  = (paddr[1:0] == 2'b00) & (paddr <= btf_pkg::REG_STATUS);
  wire        wr_ok   = access & pwrite & mapped;
  // identity, key and counter are frozen while a telegram is built
  wire        wr_lock = ~idle;
  wire [31:0] status  = {16'h0000, mac_seq, 6'h00, exhausted, ~idle};
  wire [31:0] rd_mux  =
    (paddr == btf_pkg::REG_IDENT)   ? ident :
    (paddr == btf_pkg::REG_KEY0)    ? key[31:0] :
    (paddr == btf_pkg::REG_KEY1)    ? key[63:32] :
    (paddr == btf_pkg::REG_KEY2)    ? key[95:64] :
    (paddr == btf_pkg::REG_KEY3)    ? key[127:96] :
    (paddr == btf_pkg::REG_COUNTER) ? counter :
    (paddr == btf_pkg::REG_CTRL)    ? {31'h0000_0000, enable} :
    (paddr == btf_pkg::REG_STATUS)  ? status : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite & mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  // software may only move the counter forward
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ident   <= UNIT_ID_INIT;
      key     <= btf_pkg::KEY_RESET;
      counter <= btf_pkg::COUNTER_RESET;
      enable  <= btf_pkg::ENABLE_RESET;
    end
    else
    begin
      if (start)
        counter <= counter + 32'h0000_0001; // RULE24 RULE5
      else if (wr_ok && !wr_lock && paddr == btf_pkg::REG_COUNTER && pwdata > counter)
        counter <= pwdata; // RULE5
      if (wr_ok && !wr_lock && paddr == btf_pkg::REG_IDENT)
        ident <= pwdata;
      if (wr_ok && !wr_lock && paddr == btf_pkg::REG_KEY0)
        key[31:0] <= pwdata;
      if (wr_ok && !wr_lock && paddr == btf_pkg::REG_KEY1)
        key[63:32] <= pwdata;
      if (wr_ok && !wr_lock && paddr == btf_pkg::REG_KEY2)
        key[95:64] <= pwdata;
      if (wr_ok && !wr_lock && paddr == btf_pkg::REG_KEY3)
        key[127:96] <= pwdata;
      if (wr_ok && paddr == btf_pkg::REG_CTRL)
        enable <= pwdata[btf_pkg::CTRL_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_preamble_start: assert property (tx_valid && byte_idx < 5'd4 |-> tx_data == 8'h00 ##0
    1'b1) else $error("preamble byte not zero"); // RULE19
  a_start_byte: assert property (tx_valid && byte_idx == 5'd4 |-> tx_data == 8'hA7)
    else $error("start byte wrong"); // RULE19
  a_frame_length: assert property (tx_valid && byte_idx == 5'd5 |-> tx_data == 8'h18)
    else $error("length byte wrong"); // RULE20
  a_frame_ctrl: assert property (tx_valid && byte_idx == 5'd6 && tx_ready |=>
    tx_valid && byte_idx == 5'd7 && tx_data == 8'h08) else $error("frame control wrong"); // RULE21
  a_ctrl_word: assert property (tx_valid && byte_idx == 5'd13 |-> tx_data == 8'h8C)
    else $error("control word low byte wrong"); // RULE3
  a_counter_step: assert property (start |=> counter == $past(counter) + 32'h0000_0001)
    else $error("counter did not advance"); // RULE24
  a_counter_mono: assert property (counter >= $past(counter))
    else $error("counter went backwards"); // RULE5
  a_push_code: assert property (start && push_ev && contacts == 4'b0001 |=> cmd == 8'h12)
    else $error("push code wrong"); // RULE6
  a_release_odd: assert property (start && rel_ev |=> cmd[0]) else $error("release not odd"); // RULE8
  a_nonce_status: assert property (aes_req && op != 2'd1 |-> aes_out.block[23:16] == 8'h05)
    else $error("nonce status byte wrong"); // RULE11
  a_aes_hold: assert property (aes_req && !aes_ack |=> aes_req && $stable(aes_out.block))
    else $error("cipher request dropped"); // RULE10
  a_frame_end: assert property (tx_valid && tx_last && tx_ready |=> !tx_valid ##1 idle)
    else $error("frame did not close"); // RULE1
  a_apb_answer: assert property (setup |=> pready ##1 !pready) else $error("apb answer late");

  c_push_frame: cover property (start && push_ev ##[1:200] tx_last);
  c_release_frame: cover property (start && rel_ev ##[1:200] tx_last);
  c_sink_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
  c_bad_addr: cover property (access && pslverr);

endmodule

`default_nettype wire

// >>> inc/btf_pkg.sv
/*
  Package for the button telegram framer: register map, frame layout,
  field values and the carrier struct towards the block cipher.
  Assumes a 32-bit APB master and an external AES-128 encryption engine.
*/
package btf_pkg;

  // register byte offsets
  localparam logic [7:0] REG_IDENT   = 8'h00;
  localparam logic [7:0] REG_KEY0    = 8'h04;
  localparam logic [7:0] REG_KEY1    = 8'h08;
  localparam logic [7:0] REG_KEY2    = 8'h0C;
  localparam logic [7:0] REG_KEY3    = 8'h10;
  localparam logic [7:0] REG_COUNTER = 8'h14;
  localparam logic [7:0] REG_CTRL    = 8'h18;
  localparam logic [7:0] REG_STATUS  = 8'h1C;

  // field positions
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_EXHAUST_BIT = 1;
  localparam int STAT_SEQ_LSB     = 8;

  // reset values
  localparam logic [31:0]  COUNTER_RESET = 32'h0000_0000;
  localparam logic [127:0] KEY_RESET     = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
  localparam logic         ENABLE_RESET  = 1'b1;
  localparam logic [7:0]   MAC_SEQ_RESET = 8'h00;

  // frame constants
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0]  START_BYTE    = 8'hA7;
  localparam logic [7:0]  LENGTH_BYTE   = 8'h18;
  localparam logic [15:0] FRAME_CTRL    = 16'h0801;
  localparam logic [7:0]  BCAST_BYTE    = 8'hFF;
  localparam logic [15:0] TELEGRAM_CTRL = 16'h308C;
  localparam logic [4:0]  FRAME_BYTES   = 5'd30;
  localparam logic [4:0]  IDX_LENGTH    = 5'd5;
  localparam logic [4:0]  IDX_CRC_LO    = 5'd28;
  localparam logic [4:0]  IDX_LAST      = 5'd29;

  // check sum: reflected x^16+x^12+x^5+1, zero start
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC_INIT      = 16'h0000;

  // signature mode: 13-byte nonce, 4-byte tag, no message
  localparam logic [7:0]  NONCE_STATUS = 8'h05;
  localparam logic [7:0]  CCM_B0_FLAGS = 8'h49;
  localparam logic [7:0]  CCM_A0_FLAGS = 8'h01;
  localparam logic [15:0] AUTH_LEN     = 16'h000B;

  // commands, push codes; release is the code plus one
  localparam logic [7:0] CMD_NONE    = 8'h10;
  localparam logic [7:0] CMD_BS      = 8'h12;
  localparam logic [7:0] CMD_BF      = 8'h14;
  localparam logic [7:0] CMD_AS      = 8'h18;
  localparam logic [7:0] CMD_AF      = 8'h22;
  localparam logic [7:0] CMD_BFBS    = 8'h16;
  localparam logic [7:0] CMD_ASBS    = 8'h1A;
  localparam logic [7:0] CMD_ASBF    = 8'h1C;
  localparam logic [7:0] CMD_AFBS    = 8'h1E;
  localparam logic [7:0] CMD_AFBF    = 8'h62;
  localparam logic [7:0] CMD_AFAS    = 8'h64;

  // request towards the cipher engine
  typedef struct packed {
    logic [127:0] block;
    logic [127:0] key;
  } btf_aes_req_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_SEND  = 2'b11
  } btf_state_e;

endpackage

// >>> sim/btf_partner.sv
/*
  Far-side stand-in for the framer: a keyed cipher substitute and a radio
  byte sink that captures the last frame and the last three cipher blocks.
  Assumes the framer's req/ack cipher handshake and valid/ready stream.
*/
`timescale 1ns/1ps
`default_nettype none
module btf_partner (
  // clock, reset, pacing
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  slow,
  // cipher side
  input  wire logic                  aes_req,
  input  wire btf_pkg::btf_aes_req_s aes_out,
  output logic                       aes_ack,
  output logic [127:0]               aes_result,
  // byte sink
  input  wire logic [7:0]            tx_data,
  input  wire logic                  tx_valid,
  input  wire logic                  tx_last,
  output logic                       tx_ready,
  // capture
  output logic [239:0]               frame,
  output logic [29:0]                lastv,
  output logic [383:0]               blks,
  output int                         nbytes
);
  int wait_cnt;

  ////////////////////////////////////////////////////////////////////////
  // keyed rotate-xor, not real aes: checks chaining and layout, not the cipher
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aes_ack    <= 1'b0;
      aes_result <= '0;
      wait_cnt   <= 0;
      blks       <= '0;
    end
    else if (aes_req && !aes_ack && wait_cnt >= (slow ? 5 : 0))
    begin
      aes_ack    <= 1'b1;
      aes_result <= {aes_out.block[126:0], aes_out.block[127]} ^ aes_out.key;
      blks       <= {blks[255:0], aes_out.block};
      wait_cnt   <= 0;
    end
    else
    begin
      aes_ack    <= 1'b0;
      aes_result <= ~aes_result; // no stale value outside an answer
      wait_cnt   <= aes_req && !aes_ack ? wait_cnt + 1 : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sink stalls every other cycle in slow mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_ready <= 1'b0;
      nbytes   <= 0;
    end
    else
    begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready)
      begin
        frame  <= {frame[231:0], tx_data};
        lastv  <= {lastv[28:0], tx_last};
        nbytes <= nbytes + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
/*
  Testbench for the button telegram framer: apb setup, every contact code
  on push and release, counter writes, disable and counter exhaustion.
  Assumes btf_partner as cipher stand-in and byte sink.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0]  UID = 32'hC0DE_0042; // arbitrary value
  localparam logic [127:0] KEY = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic bar, slow, aes_req, aes_ack, tx_valid, tx_last, tx_ready;
  logic [7:0] paddr, tx_data, seq;
  logic [31:0] pwdata, prdata, rd, ctr, last_ctr;
  logic [3:0] ct; // a_first a_second b_first b_second
  logic [127:0] aes_result;
  btf_pkg::btf_aes_req_s aes_out;
  logic [239:0] frame;
  logic [29:0] lastv;
  logic [383:0] blks;
  int nbytes, err_count, num_checks;
  logic [3:0] pat [11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA, 4'hC};
  logic [7:0] cmd [11] = '{8'h10, 8'h12, 8'h14, 8'h18, 8'h22, 8'h16, 8'h1A, 8'h1C, 8'h1E,
                           8'h62, 8'h64};

  btf_framer #(.UNIT_ID_INIT(UID)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .energy_bar(bar), .contact_a_first(ct[3]), .contact_a_second(ct[2]),
    .contact_b_first(ct[1]), .contact_b_second(ct[0]), .aes_req(aes_req),
    .aes_out(aes_out), .aes_ack(aes_ack), .aes_result(aes_result), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

  btf_partner FAR (
    .pclk(pclk), .presetn(presetn), .slow(slow), .aes_req(aes_req), .aes_out(aes_out),
    .aes_ack(aes_ack), .aes_result(aes_result), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .frame(frame), .lastv(lastv), .blks(blks),
    .nbytes(nbytes));

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] le32(input logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction

  function automatic logic [127:0] ciph(input logic [127:0] x);
    return {x[126:0], x[127]} ^ KEY;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [383:0] ex, input logic [383:0] got);
    num_checks++;
    if (got !== ex)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  // one apb transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      chk("apb answer", 1, 0);
      stop_test();
    end
  endtask

  // one bar edge and the full check of the telegram it yields
  task automatic tel(input logic [3:0] c, input logic up, input logic [7:0] cd);
    int n, b;
    logic [103:0] nc;
    logic [127:0] b0, b1, a0, x1, x2, y;
    logic [15:0] cr;
    logic [239:0] ef;
    b = nbytes;
    @(posedge pclk);
    if (up)
    begin
      ct <= c;
      @(posedge pclk);
    end
    bar <= up;
    if (!up)
      ct <= 4'h0; // contacts let go together with the bar
    for (n = 0; n < 3000 && nbytes != b + 30; n++)
      @(posedge pclk);
    if (n >= 3000)
    begin
      chk("frame done", 1, 0);
      stop_test();
    end
    repeat (3) @(posedge pclk);
    ctr = ctr + 1;
    seq = seq + 1;
    nc = {le32(UID), le32(UID), le32(ctr), 8'h05};
    b0 = {8'h49, nc, 16'h0000};
    a0 = {8'h01, nc, 16'h0000};
    b1 = {16'h000B, 16'h8C30, le32(UID), le32(ctr), cd, 24'h00_0000};
    x1 = ciph(b0);
    x2 = ciph(x1 ^ b1);
    y = ciph(a0);
    ef = {32'h0000_0000, 8'hA7, 8'h18, 16'h0108, seq, 32'hFFFF_FFFF, 16'h8C30, le32(UID),
          le32(ctr), cd, x2[127:96] ^ y[127:96], 16'h0000};
    cr = 16'h0000;
    for (int i = 0; i < 23; i++)
    begin
      cr ^= {8'h00, ef[199 - 8 * i -: 8]};
      for (int k = 0; k < 8; k++)
        cr = cr[0] ? (cr >> 1) ^ 16'h8408 : cr >> 1;
    end
    ef[15:0] = {cr[7:0], cr[15:8]};
    chk("sync", ef[239:200], frame[239:200]);
    chk("length", ef[199:192], frame[199:192]);
    chk("mac header", ef[191:136], frame[191:136]);
    chk("telegram ctrl", ef[135:120], frame[135:120]);
    chk("identifier", ef[119:88], frame[119:88]);
    chk("counter", ef[87:56], frame[87:56]);
    // receiver side: a counter that does not rise would be refused as a replay
    chk("counter rises", 1'b1, le32(frame[87:56]) > last_ctr);
    last_ctr = le32(frame[87:56]);
    chk("command", ef[55:48], frame[55:48]);
    chk("signature", ef[47:16], frame[47:16]);
    chk("check sum", ef[15:0], frame[15:0]);
    chk("cipher blocks", {b0, x1 ^ b1, a0}, blks);
    chk("last flag", 30'h0000_0001, lastv);
  endtask

  // a bar edge that must yield nothing
  task automatic drop(input logic lvl);
    int b;
    b = nbytes;
    @(posedge pclk);
    bar <= lvl;
    repeat (60) @(posedge pclk);
    chk("dropped event", b, nbytes);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, bar, slow} = '0;
    {paddr, pwdata, ct, ctr, seq, last_ctr} = '0;
    err_count = 0;
    num_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, btf_pkg::REG_IDENT, 32'h0000_0000);
    chk("ident", UID, rd);
    apb(1'b0, btf_pkg::REG_CTRL, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0001, rd);
    apb(1'b0, btf_pkg::REG_COUNTER, 32'h0000_0000);
    chk("counter reset", 32'h0000_0000, rd);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped error", 1'b1, er);
    for (int i = 0; i < 4; i++)
      apb(1'b1, btf_pkg::REG_KEY0 + 8'(4 * i), KEY[32 * i +: 32]);
    for (int i = 0; i < 11; i++)
    begin
      slow <= i[0];
      tel(pat[i], 1'b1, cmd[i]);
      tel(pat[i], 1'b0, cmd[i] + 8'h01);
    end
    // a lower counter value is refused, a higher one taken
    apb(1'b1, btf_pkg::REG_COUNTER, 32'h0000_0005);
    apb(1'b0, btf_pkg::REG_COUNTER, 32'h0000_0000);
    chk("counter kept", ctr, rd);
    apb(1'b1, btf_pkg::REG_COUNTER, 32'h0000_0100);
    ctr = 32'h0000_0100;
    tel(4'h0, 1'b1, 8'h10);
    apb(1'b1, btf_pkg::REG_CTRL, 32'h0000_0000);
    drop(1'b0);
    apb(1'b1, btf_pkg::REG_CTRL, 32'h0000_0001);
    // last counter value is sent once, then no more telegrams
    apb(1'b1, btf_pkg::REG_COUNTER, 32'hFFFF_FFFE);
    ctr = 32'hFFFF_FFFE;
    tel(4'h8, 1'b1, 8'h22);
    drop(1'b0);
    apb(1'b0, btf_pkg::REG_STATUS, 32'h0000_0000);
    chk("exhausted flag", 1'b1, rd[1]);
    stop_test();
  end
endmodule
`default_nettype wire
